// *** core/rsc_pkg.sv ***
package rsc_pkg;
  // AXI4-Lite register byte addresses
  localparam logic [3:0] RSC_ADDR_BGCTRL = 4'h0;
  localparam logic [3:0] RSC_ADDR_FLAGS = 4'h4;
  localparam logic [3:0] RSC_ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] RSC_ADDR_IRQ_MASK = 4'hc;
  // Field positions
  localparam int RSC_BIT_BGEN = 3;
  localparam int RSC_BIT_LOW_VOLTAGE_RESET_FLAG = 2;
  localparam int RSC_BIT_WKRF = 0;
  // Interrupt status bits: 0 low-voltage, 1 key, 2 flash, 3 watchdog timeout
  localparam int RSC_NUM_EVT = 4;
  // Reset values
  localparam logic RSC_BGEN_RST = 1'b0;
  localparam logic RSC_WKRF_RST = 1'b0;
  // Codes
  localparam logic [7:0] RSC_FLASH_RESET_CODE = 8'h55;
  localparam logic [4:0] RSC_KEY_ENABLE = 5'h0a;
  localparam logic [4:0] RSC_KEY_DISABLE = 5'h15;
  localparam logic [4:0] RSC_KEY_POR = 5'h0a;
  // Timing
  localparam int RSC_CLK_NS = 10;
  localparam int RSC_LV_MIN_NS = 100;
  localparam int RSC_LV_MIN_CYC = (RSC_LV_MIN_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
  localparam int RSC_KEY_DELAY_NS = 80;
  localparam int RSC_KEY_DELAY_CYC = (RSC_KEY_DELAY_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
  localparam int RSC_START_NS = 320;
  localparam int RSC_START_CYC = (RSC_START_NS + RSC_CLK_NS - 1) / RSC_CLK_NS;
  localparam int RSC_CNT_W = 8;
  // Core run modes
  localparam logic [1:0] RSC_MODE_FAST = 2'h0;
  localparam logic [1:0] RSC_MODE_SLOW = 2'h1;
  localparam logic [1:0] RSC_MODE_IDLE = 2'h2;
  localparam logic [1:0] RSC_MODE_SLEEP = 2'h3;
endpackage

// *** core/rsc_lv_qual.sv ***
`timescale 1ns/1ps
module rsc_lv_qual
  import rsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic low_supply_async,
  input wire logic detect_en,
  output logic lv_qualified
);
  typedef struct packed {
    logic [2:0] sync;
    logic low;
    logic [RSC_CNT_W-1:0] cnt;
    logic qual;
  } rsc_lvq_state_t;

  rsc_lvq_state_t s_q, s_d;

  // Low supply must persist past the minimum duration before it counts
  always_comb
  begin
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], low_supply_async};
    if (s_q.sync[2] == s_q.sync[1])
    begin
      s_d.low = s_q.sync[1];
    end
    s_d.qual = 1'b0;
    if (!detect_en || !s_q.low)
    begin
      s_d.cnt = '0;
    end
    else if (s_q.cnt >= RSC_CNT_W'(RSC_LV_MIN_CYC))
    begin
      s_d.qual = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + RSC_CNT_W'(1);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign lv_qualified = s_q.qual;

  // Short dips never qualify
  short_dip_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(lv_qualified) |-> $past(s_q.low, 2) && $past(s_q.low, 8))
    else $error("Qualified without sustained low");
endmodule

// *** core/rsc_top.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Low-voltage detection always on in fast/slow
// - Only sustained low supply triggers low-voltage reset
// - Qualified low-voltage reset sets flag bit 2
// - Idle or sleep disables low-voltage detection
// - Bandgap on if detection or bit3 set
// - Unimplemented flag and control bits read zero
// - Low-voltage flag: hardware sets, software clears
// - Bit 0 holds key reset flag, zero
// - Writing 55h to flash control resets device
// - Run-mode timeout resets, sets timeout flag
// - Sleep timeout clears PC/SP, sets both flags
// - Power-on clears flags; low-voltage keeps them
// - Power-on zeroes PC, disables interrupts
// - Power-on clears watchdog, time bases, timers
// - Power-on makes ports inputs, stack top
// - Pointer registers clear only on sleep timeout
// - Bad watchdog key resets after delay
// - Key reset flag cleared only by software
module rsc_top
  import rsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic low_supply_async,
  input wire logic [1:0] run_mode,
  input wire logic wdt_timeout,
  input wire logic key_write,
  input wire logic [4:0] key_value,
  input wire logic flash_ctrl_one_write,
  input wire logic [7:0] flash_ctrl_one_value,
  input wire logic timeout_clear,
  input wire logic powerdown_set,
  output logic low_voltage_detect_en,
  output logic bandgap_on,
  output logic core_reset,
  output logic system_reset,
  output logic pc_sp_clear,
  output logic power_on_init,
  output logic timeout_status_flag,
  output logic powerdown_status_flag,
  output logic irq
);
  typedef struct packed {
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic bgen;
    logic low_voltage_reset_flag;
    logic wkrf;
    logic to_flag;
    logic pd_flag;
    logic [RSC_NUM_EVT-1:0] istat;
    logic [RSC_NUM_EVT-1:0] imask;
    logic key_pend;
    logic [RSC_CNT_W-1:0] key_cnt;
    logic [RSC_CNT_W-1:0] start_cnt;
    logic sys_rst;
    logic pcsp;
    logic por_done;
    logic por_pulse;
  } rsc_state_t;

  rsc_state_t s_q, s_d;
  logic lv_qualified;
  logic wr_fire;
  logic key_bad;
  logic flash_rst;
  logic run_to;
  logic sleep_to;
  logic any_full_rst;
  logic [RSC_NUM_EVT-1:0] evt;

  // Detection runs only in fast and slow modes; idle and sleep drop it
  assign low_voltage_detect_en = (run_mode == RSC_MODE_FAST) || (run_mode == RSC_MODE_SLOW);
  assign bandgap_on = low_voltage_detect_en || s_q.bgen;

  rsc_lv_qual u_lv_qual (
    .aclk(aclk),
    .aresetn(aresetn),
    .low_supply_async(low_supply_async),
    .detect_en(low_voltage_detect_en),
    .lv_qualified(lv_qualified)
  );

  // Reset source decode; key codes other than enable/disable are violations
  assign key_bad = key_write && (key_value != RSC_KEY_ENABLE) && (key_value != RSC_KEY_DISABLE);
  assign flash_rst = flash_ctrl_one_write && (flash_ctrl_one_value == RSC_FLASH_RESET_CODE);
  assign run_to = wdt_timeout && low_voltage_detect_en;
  assign sleep_to = wdt_timeout && !low_voltage_detect_en;
  assign any_full_rst = lv_qualified || flash_rst || run_to || (s_q.key_pend && s_q.key_cnt == '0);
  assign evt = {wdt_timeout, flash_rst, key_bad, lv_qualified};
  assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;

  // Next-state logic for bus slave, flags and reset sequencing
  always_comb
  begin
    s_d = s_q;
    s_d.por_pulse = 1'b0;
    s_d.pcsp = sleep_to;
    if (!s_q.por_done)
    begin
      // First cycle after power-on: clear status flags and raise init
      s_d.por_done = 1'b1;
      s_d.por_pulse = 1'b1;
      s_d.to_flag = 1'b0;
      s_d.pd_flag = 1'b0;
      s_d.sys_rst = 1'b1;
      s_d.start_cnt = RSC_CNT_W'(RSC_START_CYC);
    end
    // Write address and data taken independently
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_d.w_got = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end
    if (wr_fire)
    begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = 2'h0;
      if (s_q.w_strb[0])
      begin
        case (s_q.aw_addr)
          RSC_ADDR_BGCTRL: s_d.bgen = s_q.w_data[RSC_BIT_BGEN];
          RSC_ADDR_FLAGS:
          begin
            // Software may only clear by writing zero
            if (!s_q.w_data[RSC_BIT_LOW_VOLTAGE_RESET_FLAG])
            begin
              s_d.low_voltage_reset_flag = 1'b0;
            end
            if (!s_q.w_data[RSC_BIT_WKRF])
            begin
              s_d.wkrf = 1'b0;
            end
          end
          RSC_ADDR_IRQ_STAT: s_d.istat = s_q.istat & ~s_q.w_data[RSC_NUM_EVT-1:0];
          RSC_ADDR_IRQ_MASK: s_d.imask = s_q.w_data[RSC_NUM_EVT-1:0];
          default: s_d.bresp = 2'h2;
        endcase
      end
      else if (s_q.aw_addr > RSC_ADDR_IRQ_MASK || s_q.aw_addr[1:0] != 2'h0)
      begin
        s_d.bresp = 2'h2;
      end
    end
    // Read channel
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = 2'h0;
      s_d.rdata = '0;
      case (s_axi_araddr)
        RSC_ADDR_BGCTRL: s_d.rdata[RSC_BIT_BGEN] = s_q.bgen;
        RSC_ADDR_FLAGS:
        begin
          s_d.rdata[RSC_BIT_LOW_VOLTAGE_RESET_FLAG] = s_q.low_voltage_reset_flag;
          s_d.rdata[RSC_BIT_WKRF] = s_q.wkrf;
        end
        RSC_ADDR_IRQ_STAT: s_d.rdata[RSC_NUM_EVT-1:0] = s_q.istat;
        RSC_ADDR_IRQ_MASK: s_d.rdata[RSC_NUM_EVT-1:0] = s_q.imask;
        default: s_d.rresp = 2'h2;
      endcase
    end
    // Hardware sets win over software clears in the same cycle
    s_d.istat = s_d.istat | evt;
    if (lv_qualified)
    begin
      s_d.low_voltage_reset_flag = 1'b1;
    end
    // Key violation: reset follows after a fixed delay
    if (key_bad && !s_q.key_pend)
    begin
      s_d.key_pend = 1'b1;
      s_d.key_cnt = RSC_CNT_W'(RSC_KEY_DELAY_CYC - 1);
    end
    else if (s_q.key_pend && s_q.key_cnt != '0)
    begin
      s_d.key_cnt = s_q.key_cnt - RSC_CNT_W'(1);
    end
    else if (s_q.key_pend)
    begin
      s_d.key_pend = 1'b0;
      s_d.wkrf = 1'b1;
    end
    // Watchdog timeout flags; low-voltage and flash resets leave them alone
    if (run_to)
    begin
      s_d.to_flag = 1'b1;
    end
    else if (sleep_to)
    begin
      s_d.to_flag = 1'b1;
      s_d.pd_flag = 1'b1;
    end
    else if (timeout_clear)
    begin
      s_d.to_flag = 1'b0;
      s_d.pd_flag = 1'b0;
    end
    else if (powerdown_set)
    begin
      s_d.pd_flag = 1'b1;
    end
    // Hold the core for the start-up count once the source goes away
    if (any_full_rst)
    begin
      s_d.sys_rst = 1'b1;
      s_d.start_cnt = RSC_CNT_W'(RSC_START_CYC);
    end
    else if (s_q.start_cnt != '0)
    begin
      s_d.start_cnt = s_q.start_cnt - RSC_CNT_W'(1);
    end
    else
    begin
      s_d.sys_rst = 1'b0;
    end
  end

  // Register the whole state; power-on value comes from the sync reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.wkrf <= RSC_WKRF_RST;
      s_q.bgen <= RSC_BGEN_RST;
      s_q.sys_rst <= 1'b1;
      s_q.start_cnt <= RSC_CNT_W'(RSC_START_CYC);
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // One outstanding write and one read at a time
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // Reset outputs; core_reset also covers the start-up hold
  assign system_reset = s_q.sys_rst;
  assign core_reset = s_q.sys_rst;
  assign pc_sp_clear = s_q.pcsp;
  assign power_on_init = s_q.por_pulse;
  assign timeout_status_flag = s_q.to_flag;
  assign powerdown_status_flag = s_q.pd_flag;
  assign irq = |(s_q.istat & s_q.imask);

  // Checks
  lvr_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lv_qualified |=> s_q.low_voltage_reset_flag && system_reset) else $error("Low-voltage reset missed flag");
  lvr_mode_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (run_mode == RSC_MODE_FAST || run_mode == RSC_MODE_SLOW) |-> low_voltage_detect_en)
    else $error("Detection off in run mode");
  // The qualifier drops its verdict one cycle after detection is switched off
  lvr_idle_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (run_mode == RSC_MODE_IDLE || run_mode == RSC_MODE_SLEEP) |-> !low_voltage_detect_en ##1 !lv_qualified)
    else $error("Detection on in low-power mode");
  // Checked against the mode pins rather than the internal enable
  bandgap_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bandgap_on == (run_mode == RSC_MODE_FAST || run_mode == RSC_MODE_SLOW || s_q.bgen))
    else $error("Bandgap enable wrong");
  flash_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    flash_rst |=> system_reset[*8]) else $error("Flash code reset missing");
  run_timeout_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run_to && !powerdown_set && !sleep_to |=> timeout_status_flag && system_reset
      && $stable(powerdown_status_flag)) else $error("Run timeout wrong");
  sleep_timeout_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_to |=> pc_sp_clear && timeout_status_flag && powerdown_status_flag)
    else $error("Sleep timeout wrong");
  // A sleep timeout only clears the counters, it never pulls the reset line
  sleep_no_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sleep_to && !any_full_rst && !system_reset |=> !system_reset)
    else $error("Sleep timeout reset the device");
  // Low-voltage reset in run mode leaves the status flags where they were
  lvr_keeps_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lv_qualified && !wdt_timeout && !timeout_clear && !powerdown_set && s_q.por_done
      |=> $stable(timeout_status_flag) && $stable(powerdown_status_flag))
    else $error("Low-voltage reset touched status flags");
  // Init strobe is a single cycle so downstream clears happen once
  init_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    power_on_init |=> !power_on_init)
    else $error("Init pulse too long");
  key_delay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    key_bad && !s_q.key_pend |=> ##[7:9] (s_q.wkrf && system_reset)) else $error("Key reset late");
  key_flag_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(s_q.wkrf) |-> $past(wr_fire)) else $error("Key flag cleared by hardware");
  lvr_flag_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(s_q.low_voltage_reset_flag) |-> $past(wr_fire)) else $error("Low-voltage flag cleared by hardware");
  zero_bits_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:RSC_NUM_EVT] == '0) else $error("Reserved bits nonzero");
  // The core leaves reset only once the start-up count has run out
  start_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(system_reset) |-> $past(s_q.start_cnt) == '0 && !$past(any_full_rst))
    else $error("Core released early");

  cov_lvr_c: cover property (@(posedge aclk) disable iff (!aresetn) lv_qualified);
  cov_run_to_c: cover property (@(posedge aclk) disable iff (!aresetn) run_to);
  cov_key_c: cover property (@(posedge aclk) disable iff (!aresetn) key_bad);
  cov_sleep_c: cover property (@(posedge aclk) disable iff (!aresetn) sleep_to);
  cov_irq_c: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule

// *** bench/rsc_partner.sv ***
`timescale 1ns/1ps
module rsc_partner
(
  input wire logic aclk,
  output logic low_supply_async,
  output logic [1:0] run_mode,
  output logic wdt_timeout,
  output logic key_write,
  output logic [4:0] key_value,
  output logic flash_ctrl_one_write,
  output logic [7:0] flash_ctrl_one_value,
  output logic timeout_clear,
  output logic powerdown_set
);
  // Healthy supply, fast mode, all strobes quiet
  initial
  begin
    low_supply_async = 1'b0;
    run_mode = 2'h0;
    {wdt_timeout, key_write, flash_ctrl_one_write} = 3'h0;
    {timeout_clear, powerdown_set} = 2'h0;
    key_value = 5'h1f;
    flash_ctrl_one_value = 8'h00;
  end
  // Core switches its run mode
  task mode(input logic [1:0] m);
    run_mode <= m;
  endtask
  // Supply sags for n cycles; the detector output is a bare level
  task dip(input int n);
    low_supply_async <= 1'b1;
    repeat (n) @(posedge aclk);
    low_supply_async <= 1'b0;
  endtask
  // Key field write; value is scrambled after the strobe so no stale value helps
  task key(input logic [4:0] v);
    key_value <= v;
    key_write <= 1'b1;
    @(posedge aclk);
    key_write <= 1'b0;
    key_value <= ~v;
  endtask
  // Flash control write, data scrambled afterwards
  task flash(input logic [7:0] v);
    flash_ctrl_one_value <= v;
    flash_ctrl_one_write <= 1'b1;
    @(posedge aclk);
    flash_ctrl_one_write <= 1'b0;
    flash_ctrl_one_value <= ~v;
  endtask
  // One-cycle pulses: 0 overflow, 1 clear watchdog, 2 halt entry
  // Only the selected strobe is touched, so back-to-back calls with different selects never drive one signal twice
  task pulse(input int s);
    if (s == 0) wdt_timeout <= 1'b1;
    if (s == 1) timeout_clear <= 1'b1;
    if (s == 2) powerdown_set <= 1'b1;
    @(posedge aclk);
    if (s == 0) wdt_timeout <= 1'b0;
    if (s == 1) timeout_clear <= 1'b0;
    if (s == 2) powerdown_set <= 1'b0;
  endtask
endmodule

// *** bench/test_reset_source_control.sv ***
`timescale 1ns/1ps
module test_reset_source_control;
  import rsc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, run_mode, rs;
  logic low_supply_async, wdt_timeout, key_write, flash_ctrl_one_write, timeout_clear, powerdown_set;
  logic [4:0] key_value;
  logic [7:0] flash_ctrl_one_value;
  logic low_voltage_detect_en, bandgap_on, core_reset, system_reset, pc_sp_clear, power_on_init;
  logic timeout_status_flag, powerdown_status_flag, irq, bad, bg;
  int err_total, n_checks, cyc, seed, ns, np, ni;
  rsc_top rsc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .low_supply_async, .run_mode, .wdt_timeout, .key_write, .key_value,
    .flash_ctrl_one_write, .flash_ctrl_one_value, .timeout_clear, .powerdown_set,
    .low_voltage_detect_en, .bandgap_on, .core_reset, .system_reset, .pc_sp_clear, .power_on_init,
    .timeout_status_flag, .powerdown_status_flag, .irq);
  rsc_partner rsc_partner_i (.aclk, .low_supply_async, .run_mode, .wdt_timeout, .key_write,
    .key_value, .flash_ctrl_one_write, .flash_ctrl_one_value, .timeout_clear, .powerdown_set);
  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      test_done();
    end
  end
  task test_done();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] flags_exp(input logic lv, input logic wk);
    return {29'h0, lv, 1'b0, wk};
  endfunction
  function automatic logic key_bad(input logic [4:0] k);
    return k !== RSC_KEY_ENABLE && k !== RSC_KEY_DISABLE;
  endfunction
  // Handshakes are sampled at the falling edge so the rising edge acts on settled values
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rdr(input logic [3:0] a);
    logic ta, tr;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid && s_axi_rready;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Counts reset, clear and init cycles over a window
  task watch(input int n);
    {ns, np, ni} = 0;
    repeat (n)
    begin
      @(posedge aclk);
      #1;
      ns += system_reset;
      np += pc_sp_clear;
      ni += power_on_init;
    end
  endtask
  task settle();
    for (int i = 0; i < 100 && system_reset !== 1'b0; i++)
    begin
      @(posedge aclk);
      #1;
    end
  endtask
  // Main sequence
  initial
  begin
    seed = 32'hd40e854d;
    {err_total, n_checks, cyc} = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
    bg = RSC_BGEN_RST;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    watch(60);
    chk(ni, 1);
    chk(ns >= RSC_START_CYC && ns <= RSC_START_CYC + 3, 1);
    chk({timeout_status_flag, powerdown_status_flag}, 0);
    rdr(RSC_ADDR_BGCTRL);
    chk(rd, 0);
    rdr(RSC_ADDR_FLAGS);
    chk(rd, flags_exp(0, 0));
    // Random control bytes against every run mode
    repeat (4)
    begin
      // Random strobe too: a cleared byte-0 lane must leave the bit alone
      v = $random(seed);
      s_axi_wstrb <= v[7:4];
      wr(RSC_ADDR_BGCTRL, v);
      s_axi_wstrb <= 4'hf;
      if (v[4])
        bg = v[3];
      rdr(RSC_ADDR_BGCTRL);
      chk(rd, {28'h0, bg, 3'h0});
      for (int m = 0; m < 4; m++)
      begin
        rsc_partner_i.mode(m[1:0]);
        @(posedge aclk);
        #1;
        chk(low_voltage_detect_en, m < 2);
        chk(bandgap_on, m < 2 || bg);
      end
    end
    wr(RSC_ADDR_FLAGS, 32'hff);
    rdr(RSC_ADDR_FLAGS);
    chk(rd, 0);
    wr(4'h2, 0);
    chk(rs, 2'h2);
    rdr(4'h6);
    chk(rs, 2'h2);
    // Short sag ignored, long sag resets; asleep it is ignored
    rsc_partner_i.mode(RSC_MODE_FAST);
    rsc_partner_i.dip(5);
    watch(30);
    chk(ns, 0);
    rsc_partner_i.dip(25);
    watch(3);
    chk(ns, 3);
    settle();
    rdr(RSC_ADDR_FLAGS);
    chk(rd, flags_exp(1, 0));
    wr(RSC_ADDR_FLAGS, 0);
    rsc_partner_i.mode(RSC_MODE_SLEEP);
    rsc_partner_i.dip(25);
    watch(30);
    chk(ns, 0);
    rdr(RSC_ADDR_FLAGS);
    chk(rd, flags_exp(0, 0));
    rsc_partner_i.mode(RSC_MODE_FAST);
    // Both legal keys, then random ones
    for (int i = 0; i < 6; i++)
    begin
      v = i == 0 ? RSC_KEY_ENABLE : i == 1 ? RSC_KEY_DISABLE : $random(seed);
      bad = key_bad(v[4:0]);
      rsc_partner_i.key(v[4:0]);
      watch(5);
      chk(ns, 0);
      watch(10);
      chk(ns > 0, bad);
      settle();
      rdr(RSC_ADDR_FLAGS);
      chk(rd, flags_exp(0, bad));
      wr(RSC_ADDR_FLAGS, 0);
    end
    // Flash code, then a non-matching byte
    wr(RSC_ADDR_IRQ_STAT, 32'hf);
    wr(RSC_ADDR_IRQ_MASK, 0);
    for (int i = 0; i < 2; i++)
    begin
      v = i == 0 ? RSC_FLASH_RESET_CODE : RSC_FLASH_RESET_CODE ^ (($random(seed) & 8'h7f) + 8'h1);
      rsc_partner_i.flash(v[7:0]);
      watch(2);
      chk(ns > 0, i == 0);
      settle();
    end
    // Event interrupt: masked, unmasked, cleared
    chk(irq, 0);
    rdr(RSC_ADDR_IRQ_STAT);
    chk(rd, 32'h4);
    wr(RSC_ADDR_IRQ_MASK, 32'h4);
    watch(2);
    chk(irq, 1);
    wr(RSC_ADDR_IRQ_STAT, 32'h4);
    watch(2);
    chk(irq, 0);
    // Overflow while running, then while idle
    rsc_partner_i.pulse(1);
    rsc_partner_i.pulse(0);
    watch(3);
    chk(ns > 0, 1);
    chk({timeout_status_flag, powerdown_status_flag}, 2'h2);
    settle();
    rsc_partner_i.pulse(1);
    rsc_partner_i.mode(RSC_MODE_IDLE);
    // Watch from the strobe on: the clear pulse lasts a single cycle
    fork
      rsc_partner_i.pulse(0);
      watch(8);
    join
    chk(ns, 0);
    chk(np, 1);
    chk({timeout_status_flag, powerdown_status_flag}, 2'h3);
    rsc_partner_i.pulse(1);
    rsc_partner_i.pulse(2);
    watch(2);
    chk({timeout_status_flag, powerdown_status_flag}, 2'h1);
    // Mid-run reset with a key flag left set: power-on values must come back
    rsc_partner_i.key(5'h00);
    watch(12);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    watch(40);
    chk(ni, 1);
    chk(ns == RSC_START_CYC, 1);
    chk({timeout_status_flag, powerdown_status_flag}, 0);
    rdr(RSC_ADDR_FLAGS);
    chk(rd, flags_exp(0, 0));
    test_done();
  end
endmodule
